//--- rtl/hicfg_defines.vh
`ifndef HICFG_DEFINES_VH
`define HICFG_DEFINES_VH

// register offsets on the configuration port
`define HICFG_OFS_STATUS      8'hE8
`define HICFG_OFS_MASK        8'hE9
`define HICFG_OFS_PORTABLE    8'hEE
`define HICFG_OFS_SENS3       8'hF4
`define HICFG_OFS_SENS21      8'hF5
`define HICFG_OFS_BOOST3      8'hF6

// status and mask bit positions
`define HICFG_BIT_SUMMARY     7
`define HICFG_BIT_SUSPEND     4
`define HICFG_BIT_CONFIGURED  3
`define HICFG_BIT_POWER       2

// portable configuration fields
`define HICFG_BIT_KEEP_CLOCK  7
`define HICFG_BIT_LEVEL_IND   6
`define HICFG_TOUT_HI         5
`define HICFG_TOUT_LO         4
`define HICFG_TOUT_95MS       2'h0

// squelch field positions
`define HICFG_SQ3_LO          0
`define HICFG_SQ2_LO          4
`define HICFG_SQ1_LO          0

// reset values
`define HICFG_RST_MASK        8'h00
`define HICFG_RST_PORTABLE    8'h00
`define HICFG_RST_SENS        8'h00
`define HICFG_RST_STATUS      8'h00

// configuration window
`define HICFG_CFG_WINDOW_MS   95

`endif

//--- rtl/hicfg_event_flag.v
`timescale 1ns/1ps
`include "hicfg_defines.vh"

// sticky event flag: set by hardware, cleared by writing 0
module hicfg_event_flag (
    input  wire clk,
    input  wire reset_n,
    input  wire event_pulse,
    input  wire clear_req,
    output reg  flag_q
);
    wire flag_d;

    // set wins over a clear landing in the same cycle
    assign flag_d = event_pulse | (flag_q & ~clear_req);

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end
endmodule // hicfg_event_flag

//--- rtl/hicfg_regs.v
`timescale 1ns/1ps
`include "hicfg_defines.vh"

// Overview of operation
// - With the suspend enable set, entering suspend drives the interrupt pin low.
// - With the configured enable set, host configuration drives the interrupt pin low.
// - With the power update enable set, a port power update drives the interrupt pin low.
// - Mask bits 7:5 and 1:0 are reserved, read zero and do nothing.
// - The keep-clock bit holds the internal clock running in suspend, else gating is allowed.
// - With level indication set, the pin shows the suspend state as a level.
// - With level indication clear, the pin is the masked event interrupt.
// - The timeout select field at bits 5:4 is read-only and reads 00 for 95 ms.
// - The portable configuration register resets to zero.
// - Port 3 squelch level sits at bits 2:0 of its sensitivity register.
// - Port 2 squelch level sits at bits 6:4 of the paired sensitivity register.
// - The suspend flag sets on suspend entry and clears only on a written 0.
// - Writing 0 to the summary bit releases the pin high; writing 1 does nothing.
module hicfg_regs #(
    parameter SQ_W = 3
) (
    input  wire            clk,
    input  wire            reset_n,
    input  wire            cfg_wr,
    input  wire            cfg_rd,
    input  wire [7:0]      cfg_addr,
    input  wire [7:0]      cfg_wdata,
    output reg  [7:0]      cfg_rdata,
    input  wire            hub_suspended,
    input  wire            hub_configured_pulse,
    input  wire            port_power_update_pulse,
    output reg             int_n,
    output reg             keep_clock_in_suspend,
    output reg  [1:0]      config_timeout_select,
    output reg  [SQ_W-1:0] port3_squelch_level,
    output reg  [SQ_W-1:0] port2_squelch_level,
    output reg  [SQ_W-1:0] port1_squelch_level
);
    reg  [7:0] mask_q;
    reg  [7:0] portable_q;
    reg  [7:0] sens3_q;
    reg  [7:0] sens21_q;
    reg        susp_prev_q;
    reg        summary_q;
    reg  [7:0] rdata_d;
    wire       wr_status;
    wire       susp_entry;
    wire       flag_susp;
    wire       flag_cfg;
    wire       flag_pwr;
    wire       ev_any;
    wire       summary_d;
    wire       int_n_d;
    wire [2:0] ev_pulse;
    wire [2:0] ev_clear;
    wire [2:0] ev_flag;
    wire [2:0] ev_enable;
    wire       wr_mask;
    wire       wr_portable;
    wire       wr_sens3;
    wire       wr_sens21;
    wire       clr_summary;

    // event slots shared by the flag loop, the enables and the clear decode
    localparam EV_SUSP = 2;
    localparam EV_CFG  = 1;
    localparam EV_PWR  = 0;

    assign wr_status   = cfg_wr && (cfg_addr == `HICFG_OFS_STATUS);
    assign wr_mask     = cfg_wr && (cfg_addr == `HICFG_OFS_MASK);
    assign wr_portable = cfg_wr && (cfg_addr == `HICFG_OFS_PORTABLE);
    assign wr_sens3    = cfg_wr && (cfg_addr == `HICFG_OFS_SENS3);
    assign wr_sens21   = cfg_wr && (cfg_addr == `HICFG_OFS_SENS21);
    // the boost register and unmapped addresses decode to no write at all

    // suspend is a level; only its rising edge counts as an event
    assign susp_entry  = hub_suspended & ~susp_prev_q;

    assign ev_pulse[EV_SUSP]  = susp_entry;
    assign ev_pulse[EV_CFG]   = hub_configured_pulse;
    assign ev_pulse[EV_PWR]   = port_power_update_pulse;

    assign ev_enable[EV_SUSP] = mask_q[`HICFG_BIT_SUSPEND];
    assign ev_enable[EV_CFG]  = mask_q[`HICFG_BIT_CONFIGURED];
    assign ev_enable[EV_PWR]  = mask_q[`HICFG_BIT_POWER];

    // a written 0 clears a flag, a written 1 leaves it alone
    assign ev_clear[EV_SUSP]  = wr_status & ~cfg_wdata[`HICFG_BIT_SUSPEND];
    assign ev_clear[EV_CFG]   = wr_status & ~cfg_wdata[`HICFG_BIT_CONFIGURED];
    assign ev_clear[EV_PWR]   = wr_status & ~cfg_wdata[`HICFG_BIT_POWER];

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_flag
            hicfg_event_flag u_flag (
                .clk         (clk),
                .reset_n     (reset_n),
                .event_pulse (ev_pulse[gi]),
                .clear_req   (ev_clear[gi]),
                .flag_q      (ev_flag[gi])
            );
        end
    endgenerate

    assign flag_susp = ev_flag[EV_SUSP];
    assign flag_cfg  = ev_flag[EV_CFG];
    assign flag_pwr  = ev_flag[EV_PWR];

    assign ev_any = |(ev_pulse & ev_enable);

    // summary released by a written 0, a written 1 does nothing
    assign clr_summary = wr_status & ~cfg_wdata[`HICFG_BIT_SUMMARY];

    // a fresh enabled event in the clearing cycle wins, so no event is lost
    assign summary_d   = ev_any | (summary_q & ~clr_summary);

    // pin role chosen by level indication bit
    assign int_n_d = portable_q[`HICFG_BIT_LEVEL_IND] ? ~hub_suspended : ~summary_d;

    // pin and edge history; the pin comes from a flop so decode glitches never reach it
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            susp_prev_q <= 1'b0;
            summary_q   <= 1'b0;
            int_n       <= 1'b1;
        end else begin
            susp_prev_q <= hub_suspended;
            summary_q   <= summary_d;
            int_n       <= int_n_d;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_q <= `HICFG_RST_MASK;
        end else if (wr_mask) begin
            mask_q <= cfg_wdata & 8'h1C;
        end
    end

    // timeout field is not writable; register resets to zero
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            portable_q <= `HICFG_RST_PORTABLE;
        end else if (wr_portable) begin
            portable_q <= cfg_wdata & 8'hC0;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sens3_q <= `HICFG_RST_SENS;
        end else if (wr_sens3) begin
            sens3_q <= cfg_wdata & 8'h07;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sens21_q <= `HICFG_RST_SENS;
        end else if (wr_sens21) begin
            sens21_q <= cfg_wdata & 8'h77;
        end
    end

    // read mux; reserved bits and unmapped addresses read zero
    always @* begin
        rdata_d = 8'h00;
        case (cfg_addr)
            `HICFG_OFS_STATUS: begin
                rdata_d[`HICFG_BIT_SUMMARY]    = summary_q;
                rdata_d[`HICFG_BIT_SUSPEND]    = flag_susp;
                rdata_d[`HICFG_BIT_CONFIGURED] = flag_cfg;
                rdata_d[`HICFG_BIT_POWER]      = flag_pwr;
            end
            `HICFG_OFS_MASK:     rdata_d = mask_q;
            `HICFG_OFS_PORTABLE: begin
                rdata_d = portable_q;
                rdata_d[`HICFG_TOUT_HI:`HICFG_TOUT_LO] = `HICFG_TOUT_95MS;
            end
            `HICFG_OFS_SENS3:    rdata_d = sens3_q;
            `HICFG_OFS_SENS21:   rdata_d = sens21_q;
            // drive boost stays reserved here: writes dropped, reads zero
            `HICFG_OFS_BOOST3:   rdata_d = 8'h00;
            default:             rdata_d = 8'h00;
        endcase
    end

    // read data stands one cycle and is zero otherwise, so no stale byte lingers
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_rdata <= 8'h00;
        end else begin
            cfg_rdata <= cfg_rd ? rdata_d : 8'h00;
        end
    end

    // config outputs from flops
    // the gate itself sits outside; this block only offers the keep request
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            keep_clock_in_suspend <= 1'b0;
            config_timeout_select <= `HICFG_TOUT_95MS;
            port3_squelch_level   <= {SQ_W{1'b0}};
            port2_squelch_level   <= {SQ_W{1'b0}};
            port1_squelch_level   <= {SQ_W{1'b0}};
        end else begin
            keep_clock_in_suspend <= portable_q[`HICFG_BIT_KEEP_CLOCK];
            config_timeout_select <= `HICFG_TOUT_95MS;
            port3_squelch_level   <= sens3_q[`HICFG_SQ3_LO +: SQ_W];
            port2_squelch_level   <= sens21_q[`HICFG_SQ2_LO +: SQ_W];
            port1_squelch_level   <= sens21_q[`HICFG_SQ1_LO +: SQ_W];
        end
    end
endmodule // hicfg_regs

//--- verification/hicfg_regs_properties.sv
`timescale 1ns/1ps
module hicfg_chk (
    input logic       clk,
    input logic       reset_n,
    input logic       cfg_wr,
    input logic       cfg_rd,
    input logic [7:0] cfg_addr,
    input logic [7:0] cfg_wdata,
    input logic [7:0] cfg_rdata,
    input logic       hub_suspended,
    input logic       hub_configured_pulse,
    input logic       port_power_update_pulse,
    input logic       int_n,
    input logic       keep_clock_in_suspend,
    input logic [1:0] config_timeout_select,
    input logic [2:0] port3_squelch_level,
    input logic [2:0] port2_squelch_level,
    input logic [2:0] port1_squelch_level
);
    logic [7:0] msk_q, prt_q;
    wire w_e8 = cfg_wr && cfg_addr == 8'hE8;
    wire w_ee = cfg_wr && cfg_addr == 8'hEE;
    wire ev = !prt_q[6];
    always @(posedge clk or negedge reset_n)
        if (!reset_n) {msk_q, prt_q} <= 16'h0000;
        else if (cfg_wr && cfg_addr == 8'hE9) msk_q <= cfg_wdata;
        else if (w_ee) prt_q <= cfg_wdata;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_keep_clock: assert property (w_ee |-> ##2
        keep_clock_in_suspend == $past(cfg_wdata[7], 2)) else $error("keep bit wrong");
    a_sq3_field: assert property (cfg_wr && cfg_addr == 8'hF4 |-> ##2
        port3_squelch_level == $past(cfg_wdata[2:0], 2)) else $error("port3 field wrong");
    a_sq21_field: assert property (cfg_wr && cfg_addr == 8'hF5 |-> ##2
        {port2_squelch_level, port1_squelch_level} ==
        {$past(cfg_wdata[6:4], 2), $past(cfg_wdata[2:0], 2)}) else $error("port21 field wrong");
    a_cfg_event: assert property (ev && msk_q[3] && hub_configured_pulse |=> !int_n)
        else $error("configured event missed");
    a_pwr_event: assert property (ev && msk_q[2] && port_power_update_pulse |=> !int_n)
        else $error("power event missed");
    a_susp_event: assert property (ev && msk_q[4] && $rose(hub_suspended) |-> ##[1:2] !int_n)
        else $error("suspend event missed");
    a_level_mode: assert property ($past(prt_q[6]) |-> int_n == !$past(hub_suspended))
        else $error("level pin wrong");
    a_pin_release: assert property (ev && w_e8 && !cfg_wdata[7] && !hub_configured_pulse
        && !port_power_update_pulse && $stable(hub_suspended) |=> int_n) else $error("no release");
    a_rsvd_read: assert property (cfg_rd && (cfg_addr == 8'hE9 || cfg_addr == 8'hEE) |=>
        (cfg_rdata & ($past(cfg_addr) == 8'hE9 ? 8'hE3 : 8'h3F)) == 8'h00) else $error("rsvd bits");
    a_tout_fixed: assert property (config_timeout_select == 2'b00)
        else $error("timeout code wrong");
endmodule // hicfg_chk
bind hicfg_regs hicfg_chk i_hicfg_chk (.*);

//--- verification/hicfg_cpu.sv
`timescale 1ns/1ps
module hicfg_cpu (
    output logic       cfg_wr,
    output logic       cfg_rd,
    output logic [7:0] cfg_addr,
    output logic [7:0] cfg_wdata,
    input  logic       clk
);
    initial {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = 18'h00000;
    // entered just after an edge; released lines show the inverse so no stale byte lingers
    task acc(input logic w, input logic [7:0] a, d);
        {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {w, !w, a, d};
        @(posedge clk) #1;
        {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {2'b00, ~a, ~d};
        @(posedge clk) #1;
    endtask
endmodule // hicfg_cpu

//--- verification/hicfg_regs_tb.sv
`timescale 1ns/1ps
module hicfg_regs_tb;
    logic       clk = 0, reset_n = 0, hub_suspended = 0, rd_seen = 0;
    logic       hub_configured_pulse = 0, port_power_update_pulse = 0;
    logic       cfg_wr, cfg_rd, int_n, keep_clock_in_suspend;
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, d;
    logic [1:0] config_timeout_select;
    logic [2:0] port3_squelch_level, port2_squelch_level, port1_squelch_level;
    logic [7:0] q[$];
    int         fail_count = 0, n_compared = 0, cyc = 0, seed = 32'hb3a2c937;
    wire  [8:0] sq = {port3_squelch_level, port2_squelch_level, port1_squelch_level};
    always #2.5 clk = ~clk;
    hicfg_cpu i_hicfg_cpu (.*);
    hicfg_regs #(.SQ_W(3)) i_hicfg_regs (.*);
    task chk(input string n, input logic [15:0] e, g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task results;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task wr(input logic [7:0] a, v);
        i_hicfg_cpu.acc(1'b1, a, v);
    endtask
    task rd(input logic [7:0] a, e);
        q.push_back(e);
        i_hicfg_cpu.acc(1'b0, a, 8'h00);
    endtask
    task tick;
        @(posedge clk) #1;
    endtask
    task pin(input logic e);
        tick;
        tick;
        chk("int_n", e, int_n);
    endtask
    // read data is valid for the one cycle after the read edge
    always @(posedge clk) rd_seen <= cfg_rd;
    always @(negedge clk) if (rd_seen && q.size() > 0) chk("cfg_rdata", q.pop_front(), cfg_rdata);
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        #1 reset_n = 1;
        rd(8'hEE, 8'h00);
        wr(8'hEE, 8'hFF);
        chk("keep_clock", 16'h0001, keep_clock_in_suspend);
        chk("timeout", 16'h0000, config_timeout_select);
        rd(8'hEE, 8'hC0);
        wr(8'hEE, 8'h00);
        wr(8'hE9, 8'hFF);
        rd(8'hE9, 8'h1C);
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            wr(8'hF4, {d[7:3], i[2:0]});
            wr(8'hF5, {d[7], i[2:0], d[3], ~i[2:0]});
            chk("squelch", {i[2:0], i[2:0], ~i[2:0]}, sq);
        end
        for (int k = 0; k < 3; k++) begin
            {hub_suspended, hub_configured_pulse, port_power_update_pulse} = 3'b100 >> k;
            tick;
            {hub_configured_pulse, port_power_update_pulse} = 2'b00;
            pin(1'b0);
            wr(8'hE8, 8'hFF);
            rd(8'hE8, 8'h80 | (8'h10 >> k));
            wr(8'hE8, 8'h00);
            chk("int_n", 16'h0001, int_n);
        end
        wr(8'hE9, 8'hE3);
        hub_configured_pulse = 1;
        tick;
        hub_configured_pulse = 0;
        pin(1'b1);
        rd(8'hE8, 8'h08);
        wr(8'hEE, 8'hC0);
        hub_suspended = 1;
        pin(1'b0);
        hub_suspended = 0;
        pin(1'b1);
        reset_n = 0;
        tick;
        chk("reset", 16'h0001, {keep_clock_in_suspend, sq, int_n});
        reset_n = 1;
        rd(8'hEE, 8'h00);
        results();
    end
endmodule // hicfg_regs_tb
